//--- inc/urs_consts.svh
// register offsets, field positions and reset values of the used-ring block
`ifndef URS_CONSTS_SVH
`define URS_CONSTS_SVH
`define URS_OFF_CTRL       8'h00
`define URS_OFF_QSIZE      8'h04
`define URS_OFF_AVAIL_BASE 8'h08
`define URS_OFF_USED_BASE  8'h0c
`define URS_OFF_AVAIL_EVT  8'h10
`define URS_OFF_STATUS     8'h14
`define URS_CTRL_EVT_BIT   0
`define URS_CTRL_SUP_BIT   1
`define URS_ST_BUSY_BIT    16
`define URS_ST_KICK_BIT    17
`define URS_QLOG_RST       4'h0
`define URS_RING_HDR       32'h0000_0004
`define URS_IDX_OFF        32'h0000_0002
`define URS_ELEM_BYTES_LOG 3
`define URS_AVAIL_ENT_LOG  1
`endif

//--- inc/urs_pkg.sv
// types of the used-ring block
package urs_pkg;
   typedef enum logic [3:0] {
      URS_IDLE, URS_W_ID, URS_W_LEN, URS_W_IDX, URS_RD_FLAGS, URS_RD_EVT,
      URS_DECIDE, URS_PUB_FLAGS, URS_PUB_EVT
   } urs_state_t;
   typedef struct packed {
      logic evt;
      logic sup;
      logic [3:0] qlog;
      logic [31:0] abase;
      logic [31:0] ubase;
      logic [15:0] aevt;
      logic [15:0] uidx;
      logic kick;
      logic pub;
      urs_state_t st;
      logic [31:0] id;
      logic [31:0] len;
      logic [15:0] old_idx;
      logic aflag;
      logic [15:0] uevt;
      logic mem_req;
      logic mem_we;
      logic [31:0] mem_addr;
      logic [31:0] mem_wdata;
      logic [3:0] mem_be;
      logic wb_ack;
      logic [31:0] wb_dat;
      logic irq;
   } urs_regs_t;
endpackage

//--- core/urs_used_ring.sv
// device side of a split virtual queue: used-ring writer and event suppression
//
// How it works
// - without event index, threshold is ignored
// - without event index, interrupt when flags bit 0 is clear
// - with event index, interrupt when position equals threshold
// - threshold compare on 16-bit wrapping position
// - element holds 32-bit head id, 32-bit length
// - ring: flags, position, elements, trailing notify threshold
// - position starts at 0, slot is position mod size
// - only the device writes the used ring
// - length written before position is advanced
// - reported length never exceeds bytes written
// - used flags only 0 or 1 without index
// - used flags 0 with index, publish threshold
// - device tolerates spurious notifications
`timescale 1ns/100ps
`include "urs_consts.svh"
module urs_used_ring import urs_pkg::*; (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // completed chains from the processing engine
   input wire logic cmp_valid_i,
   input wire logic [31:0] cmp_id_i,
   input wire logic [31:0] cmp_len_i,
   input wire logic [31:0] cmp_written_i,
   output logic cmp_ready_o,
   // shared memory master
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [31:0] mem_addr_o,
   output logic [31:0] mem_wdata_o,
   output logic [3:0] mem_be_o,
   input wire logic mem_ack_i,
   input wire logic [31:0] mem_rdata_i,
   // driver kick and completion interrupt
   input wire logic notify_i,
   output logic irq_o
);
   urs_regs_t s_ff, nxt_s;

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] hw_data(input logic [31:0] a, input logic [15:0] v);
      return a[1] ? {v, 16'h0000} : {16'h0000, v};
   endfunction

   function automatic logic [3:0] hw_be(input logic [31:0] a);
      return a[1] ? 4'hc : 4'h3;
   endfunction

   function automatic logic [15:0] hw_sel(input logic [31:0] a, input logic [31:0] d);
      return a[1] ? d[31:16] : d[15:0];
   endfunction

   // slot = position mod queue size; queue size is a power of two
   function automatic logic [31:0] elem_addr(input logic [31:0] base, input logic [15:0] idx,
                                             input logic [3:0] ql);
      logic [15:0] slot;
      slot = idx & 16'((32'h1 << ql) - 32'h1);
      return base + `URS_RING_HDR + ({16'h0000, slot} << `URS_ELEM_BYTES_LOG);
   endfunction

   logic [31:0] qsz;
   logic [31:0] tail_used;
   logic [31:0] tail_avail;
   logic wb_req;
   logic [31:0] aevt_m;
   logic [15:0] rd_half;
   assign qsz = 32'h1 << s_ff.qlog;
   assign tail_used = s_ff.ubase + `URS_RING_HDR + (qsz << `URS_ELEM_BYTES_LOG);
   assign tail_avail = s_ff.abase + `URS_RING_HDR + (qsz << `URS_AVAIL_ENT_LOG);
   assign wb_req = wb_cyc_i && wb_stb_i && !s_ff.wb_ack;
   assign aevt_m = merge({16'h0000, s_ff.aevt}, wb_dat_i, wb_sel_i);
   assign rd_half = hw_sel(s_ff.mem_addr, mem_rdata_i);

   always_comb begin
      nxt_s = s_ff;
      nxt_s.wb_ack = wb_req;
      nxt_s.irq = 1'b0;
      // bus reads
      if (wb_req) begin
         case (wb_adr_i)
            `URS_OFF_CTRL: nxt_s.wb_dat = {30'h0, s_ff.sup, s_ff.evt};
            `URS_OFF_QSIZE: nxt_s.wb_dat = {28'h0, s_ff.qlog};
            `URS_OFF_AVAIL_BASE: nxt_s.wb_dat = s_ff.abase;
            `URS_OFF_USED_BASE: nxt_s.wb_dat = s_ff.ubase;
            `URS_OFF_AVAIL_EVT: nxt_s.wb_dat = {16'h0000, s_ff.aevt};
            `URS_OFF_STATUS: nxt_s.wb_dat = {14'h0, s_ff.kick, s_ff.st != URS_IDLE, s_ff.uidx};
            default: nxt_s.wb_dat = 32'h0000_0000;
         endcase
      end
      // bus writes; a hint change queues a publish of flags and threshold
      if (wb_req && wb_we_i) begin
         case (wb_adr_i)
            `URS_OFF_CTRL: begin
               if (wb_sel_i[0]) begin
                  nxt_s.evt = wb_dat_i[`URS_CTRL_EVT_BIT];
                  nxt_s.sup = wb_dat_i[`URS_CTRL_SUP_BIT];
                  nxt_s.pub = 1'b1;
               end
            end
            `URS_OFF_QSIZE: begin
               if (wb_sel_i[0]) begin
                  nxt_s.qlog = (wb_dat_i[3:0] == 4'hf) ? 4'hf : wb_dat_i[3:0];
               end
            end
            `URS_OFF_AVAIL_BASE:
               nxt_s.abase = merge(s_ff.abase, wb_dat_i, wb_sel_i) & 32'hffff_fffe;
            `URS_OFF_USED_BASE:
               nxt_s.ubase = merge(s_ff.ubase, wb_dat_i, wb_sel_i) & 32'hffff_fffc;
            `URS_OFF_AVAIL_EVT: begin
               nxt_s.aevt = aevt_m[15:0];
               nxt_s.pub = 1'b1;
            end
            default: begin
            end
         endcase
      end
      // kick flag: clear by writing one, a fresh kick in the same cycle wins
      if (wb_req && wb_we_i && wb_adr_i == `URS_OFF_STATUS && wb_sel_i[2] &&
          wb_dat_i[`URS_ST_KICK_BIT]) begin
         nxt_s.kick = 1'b0;
      end
      if (notify_i) begin
         nxt_s.kick = 1'b1;
      end
      case (s_ff.st)
         URS_IDLE: begin
            if (s_ff.pub && !(wb_req && wb_we_i)) begin
               nxt_s.pub = 1'b0;
               nxt_s.st = URS_PUB_FLAGS;
               nxt_s.mem_req = 1'b1;
               nxt_s.mem_we = 1'b1;
               nxt_s.mem_addr = s_ff.ubase;
               // flags word is 0 or 1, and forced to 0 with the event index
               nxt_s.mem_wdata = hw_data(s_ff.ubase, {15'h0, s_ff.sup && !s_ff.evt});
               nxt_s.mem_be = hw_be(s_ff.ubase);
            end else if (cmp_valid_i && !s_ff.pub) begin
               nxt_s.id = cmp_id_i;
               // under-report when the engine wrote fewer bytes than it claims
               nxt_s.len = (cmp_len_i > cmp_written_i) ? cmp_written_i : cmp_len_i;
               nxt_s.old_idx = s_ff.uidx;
               nxt_s.st = URS_W_ID;
               nxt_s.mem_req = 1'b1;
               nxt_s.mem_we = 1'b1;
               nxt_s.mem_addr = elem_addr(s_ff.ubase, s_ff.uidx, s_ff.qlog);
               nxt_s.mem_wdata = cmp_id_i;
               nxt_s.mem_be = 4'hf;
            end
         end
         URS_W_ID: begin
            if (mem_ack_i) begin
               nxt_s.st = URS_W_LEN;
               nxt_s.mem_addr = s_ff.mem_addr + 32'h4;
               nxt_s.mem_wdata = s_ff.len;
            end
         end
         URS_W_LEN: begin
            // the position moves only once the element is complete in memory
            if (mem_ack_i) begin
               nxt_s.st = URS_W_IDX;
               nxt_s.mem_addr = s_ff.ubase + `URS_IDX_OFF;
               nxt_s.mem_wdata = hw_data(s_ff.ubase + `URS_IDX_OFF, s_ff.uidx + 16'h0001);
               nxt_s.mem_be = hw_be(s_ff.ubase + `URS_IDX_OFF);
            end
         end
         URS_W_IDX: begin
            if (mem_ack_i) begin
               nxt_s.uidx = s_ff.uidx + 16'h0001;
               nxt_s.st = URS_RD_FLAGS;
               nxt_s.mem_we = 1'b0;
               nxt_s.mem_addr = s_ff.abase;
               nxt_s.mem_be = hw_be(s_ff.abase);
            end
         end
         URS_RD_FLAGS: begin
            if (mem_ack_i) begin
               nxt_s.aflag = rd_half[0];
               if (s_ff.evt) begin
                  nxt_s.st = URS_RD_EVT;
                  nxt_s.mem_addr = tail_avail;
                  nxt_s.mem_be = hw_be(tail_avail);
               end else begin
                  nxt_s.mem_req = 1'b0;
                  nxt_s.st = URS_DECIDE;
               end
            end
         end
         URS_RD_EVT: begin
            if (mem_ack_i) begin
               nxt_s.uevt = rd_half;
               nxt_s.mem_req = 1'b0;
               nxt_s.st = URS_DECIDE;
            end
         end
         URS_DECIDE: begin
            // threshold only with the event index, flags bit only without it
            if (s_ff.evt) begin
               nxt_s.irq = (s_ff.old_idx == s_ff.uevt);
            end else begin
               nxt_s.irq = !s_ff.aflag;
            end
            nxt_s.st = URS_IDLE;
         end
         URS_PUB_FLAGS: begin
            if (mem_ack_i) begin
               if (s_ff.evt) begin
                  nxt_s.st = URS_PUB_EVT;
                  nxt_s.mem_addr = tail_used;
                  nxt_s.mem_wdata = hw_data(tail_used, s_ff.aevt);
                  nxt_s.mem_be = hw_be(tail_used);
               end else begin
                  nxt_s.mem_req = 1'b0;
                  nxt_s.st = URS_IDLE;
               end
            end
         end
         URS_PUB_EVT: begin
            if (mem_ack_i) begin
               nxt_s.mem_req = 1'b0;
               nxt_s.st = URS_IDLE;
            end
         end
         default: begin
            nxt_s.mem_req = 1'b0;
            nxt_s.st = URS_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_ff <= '0;
         s_ff.qlog <= `URS_QLOG_RST;
         s_ff.st <= URS_IDLE;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign wb_dat_o = s_ff.wb_dat;
   assign wb_ack_o = s_ff.wb_ack;
   assign cmp_ready_o = (s_ff.st == URS_IDLE) && !s_ff.pub;
   assign mem_req_o = s_ff.mem_req;
   assign mem_we_o = s_ff.mem_we;
   assign mem_addr_o = s_ff.mem_addr;
   assign mem_wdata_o = s_ff.mem_wdata;
   assign mem_be_o = s_ff.mem_be;
   assign irq_o = s_ff.irq;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   chk_irq_flags_clear: assert property (
      s_ff.st == URS_DECIDE && !s_ff.evt && !s_ff.aflag |=> irq_o)
      else $error("no interrupt although driver flags are clear");
   chk_irq_flags_set: assert property (
      s_ff.st == URS_DECIDE && !s_ff.evt && s_ff.aflag |=> !irq_o)
      else $error("interrupt although driver asked for none");
   chk_irq_thresh_hit: assert property (
      s_ff.st == URS_DECIDE && s_ff.evt && s_ff.old_idx == s_ff.uevt |=> irq_o)
      else $error("no interrupt at threshold position");
   chk_irq_thresh_miss: assert property (
      s_ff.st == URS_DECIDE && s_ff.evt && s_ff.old_idx != s_ff.uevt |=> !irq_o)
      else $error("interrupt away from threshold position");
   chk_irq_only_decide: assert property (
      irq_o |-> $past(s_ff.st) == URS_DECIDE)
      else $error("interrupt outside a completion");
   chk_len_before_idx: assert property (
      $rose(s_ff.st == URS_W_IDX) |-> $past(s_ff.st) == URS_W_LEN && $past(mem_ack_i))
      else $error("position written before the length");
   chk_idx_step_one: assert property (
      s_ff.uidx != $past(s_ff.uidx) |-> s_ff.uidx == $past(s_ff.uidx) + 16'h0001)
      else $error("used position moved by other than one");
   chk_len_clamped: assert property (
      cmp_valid_i && cmp_ready_o |=> s_ff.len <= $past(cmp_written_i) &&
         s_ff.len <= $past(cmp_len_i))
      else $error("reported length exceeds bytes written");
   chk_slot_addr: assert property (
      s_ff.st == URS_W_ID && mem_req_o |->
         mem_addr_o == s_ff.ubase + 32'h4 + (32'(s_ff.uidx) % qsz) * 32'h8)
      else $error("element written to wrong slot");
   chk_write_used_only: assert property (
      mem_req_o && mem_we_o |-> mem_addr_o >= s_ff.ubase && mem_addr_o <= tail_used)
      else $error("device wrote outside the used ring");
   chk_flags_word: assert property (
      s_ff.st == URS_PUB_FLAGS |-> hw_sel(mem_addr_o, mem_wdata_o) <= 16'h0001 &&
         (!s_ff.evt || hw_sel(mem_addr_o, mem_wdata_o) == 16'h0000))
      else $error("illegal used flags value");
   chk_wb_ack: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered in one cycle");

   cov_irq_thresh: cover property (s_ff.st == URS_DECIDE && s_ff.evt ##1 irq_o);
   cov_irq_flags: cover property (s_ff.st == URS_DECIDE && !s_ff.evt ##1 irq_o);
   cov_idx_wrap: cover property (s_ff.uidx == 16'h0000 && $past(s_ff.uidx) == 16'hffff);
   cov_publish: cover property (s_ff.st == URS_PUB_EVT && mem_ack_i);
endmodule

//--- tb/urs_mem_model.sv
// shared-memory partner: driver-owned rings, answers promptly or with stalls
`timescale 1ns/100ps
module urs_mem_model (
   // clock
   input wire logic clk_i,
   // memory slave side
   input wire logic req_i,
   input wire logic we_i,
   input wire logic [31:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] be_i,
   input wire logic slow_i,
   output logic ack_o,
   output logic [31:0] rdata_o
);
   logic [31:0] mem [0:63] = '{default: 32'h0};
   logic [31:0] rd_ff = 32'h0;
   logic [1:0] wait_ff = 2'h0;
   initial ack_o = 1'b0;
   // outside an answer the lines show the inverse, so stale data never looks valid
   assign rdata_o = ack_o ? rd_ff : ~rd_ff;
   always @(posedge clk_i) begin
      ack_o <= 1'b0;
      if (req_i && !ack_o) begin
         if (slow_i && wait_ff != 2'h2) begin
            wait_ff <= wait_ff + 2'h1;
         end else begin
            wait_ff <= 2'h0;
            ack_o <= 1'b1;
            rd_ff <= mem[addr_i[7:2]];
            for (int b = 0; b < 4; b++) begin
               if (we_i && be_i[b]) mem[addr_i[7:2]][8*b +: 8] <= wdata_i[8*b +: 8];
            end
         end
      end
   end
endmodule

//--- tb/urs_used_ring_tb.sv
// self-checking bench of the used-ring writer and event suppression
`timescale 1ns/100ps
`include "urs_consts.svh"
module urs_used_ring_tb;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic wb_ack_o, cmp_ready_o, mem_req_o, mem_we_o, mem_ack_i, irq_o;
   logic cmp_valid_i = 1'b0, notify_i = 1'b0, slow = 1'b0;
   logic [31:0] cmp_id_i = 32'h0, cmp_len_i = 32'h0, cmp_written_i = 32'h0;
   logic [31:0] mem_addr_o, mem_wdata_o, mem_rdata_i, q;
   logic [3:0] mem_be_o;
   int bad_count = 0;
   int cmp_count = 0;
   always #5 sys_clk_i = ~sys_clk_i;
   urs_used_ring u_urs_used_ring (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmp_valid_i(cmp_valid_i),
      .cmp_id_i(cmp_id_i), .cmp_len_i(cmp_len_i), .cmp_written_i(cmp_written_i),
      .cmp_ready_o(cmp_ready_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
      .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_be_o(mem_be_o),
      .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .notify_i(notify_i), .irq_o(irq_o));
   urs_mem_model u_mem (.clk_i(sys_clk_i), .req_i(mem_req_o), .we_i(mem_we_o),
      .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .be_i(mem_be_o), .slow_i(slow),
      .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic hang();
      bad_count++;
      $display("Error at %0t: wait ran out", $time);
      close_out();
   endtask
   // classic single cycle; entered just after a rising edge
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d);
      int n;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) hang();
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge sys_clk_i);
   endtask
   // a publish holds ready low until its ring writes are done
   task automatic idle_wait();
      int n;
      n = 0;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (cmp_ready_o !== 1'b1 && n < 60);
      if (n >= 60) hang();
   endtask
   task automatic cmp_run(input logic [31:0] id, input logic [31:0] len,
         input logic [31:0] wr, input logic [31:0] exp_irq, input logic [15:0] pos);
      int n;
      logic [31:0] irqs;
      irqs = 32'h0;
      cmp_valid_i <= 1'b1;
      cmp_id_i <= id;
      cmp_len_i <= len;
      cmp_written_i <= wr;
      idle_wait();
      cmp_valid_i <= 1'b0;
      n = 0;
      do begin
         @(posedge sys_clk_i);
         n++;
         irqs += {31'h0, irq_o === 1'b1};
      end while ((cmp_ready_o !== 1'b1 || n < 3) && n < 60);
      if (n >= 60) hang();
      repeat (2) begin
         @(posedge sys_clk_i);
         irqs += {31'h0, irq_o === 1'b1};
      end
      chk(irqs, exp_irq);
      chk(u_mem.mem[33 + 2 * pos[1:0]], id);
      chk(u_mem.mem[34 + 2 * pos[1:0]], (len < wr) ? len : wr);
      chk({16'h0, u_mem.mem[32][31:16]}, {16'h0, pos + 16'h1});
   endtask
   task automatic t_regs();
      wb_xfer(1'b0, `URS_OFF_CTRL, 32'h0);
      chk(q, 32'h0);
      wb_xfer(1'b0, `URS_OFF_QSIZE, 32'h0);
      chk(q, 32'h0);
      wb_xfer(1'b1, 8'h20, 32'hffff_ffff);
      wb_xfer(1'b0, 8'h20, 32'h0);
      chk(q, 32'h0);
      wb_xfer(1'b1, `URS_OFF_QSIZE, 32'h2);
      wb_xfer(1'b1, `URS_OFF_AVAIL_BASE, 32'h40);
      wb_xfer(1'b1, `URS_OFF_USED_BASE, 32'h80);
      wb_xfer(1'b0, `URS_OFF_QSIZE, 32'h0);
      chk(q, 32'h2);
      $display("test regs done");
   endtask
   task automatic t_plain();
      u_mem.mem[32] <= 32'hffff;
      u_mem.mem[19] <= 32'h3;
      wb_xfer(1'b1, `URS_OFF_CTRL, 32'h0);
      idle_wait();
      chk(u_mem.mem[32], 32'h0);
      u_mem.mem[16] <= 32'h0;
      cmp_run(32'h11, 32'h40, 32'h40, 32'h1, 16'h0);
      u_mem.mem[16] <= 32'h1;
      cmp_run(32'h12, 32'h64, 32'h3c, 32'h0, 16'h1);
      wb_xfer(1'b1, `URS_OFF_CTRL, 32'h2);
      idle_wait();
      chk({16'h0, u_mem.mem[32][15:0]}, 32'h1);
      $display("test plain done");
   endtask
   task automatic t_evt();
      slow <= 1'b1;
      wb_xfer(1'b1, `URS_OFF_CTRL, 32'h3);
      wb_xfer(1'b1, `URS_OFF_AVAIL_EVT, 32'h7);
      idle_wait();
      chk({16'h0, u_mem.mem[32][15:0]}, 32'h0);
      chk({16'h0, u_mem.mem[41][15:0]}, 32'h7);
      u_mem.mem[16] <= 32'h0;
      u_mem.mem[19] <= 32'h4;
      cmp_run(32'h21, 32'h8, 32'h9, 32'h0, 16'h2);
      cmp_run(32'h22, 32'h8, 32'h8, 32'h0, 16'h3);
      cmp_run(32'h23, 32'h1, 32'h0, 32'h1, 16'h4);
      cmp_run(32'h24, 32'h2, 32'h2, 32'h0, 16'h5);
      slow <= 1'b0;
      $display("test event index done");
   endtask
   task automatic t_notify();
      notify_i <= 1'b1;
      @(posedge sys_clk_i);
      notify_i <= 1'b0;
      @(posedge sys_clk_i);
      wb_xfer(1'b0, `URS_OFF_STATUS, 32'h0);
      chk(q, 32'h0002_0006);
      wb_xfer(1'b1, `URS_OFF_STATUS, 32'h0002_0000);
      wb_xfer(1'b0, `URS_OFF_STATUS, 32'h0);
      chk(q, 32'h0000_0006);
      $display("test notify done");
   endtask
   initial begin
      repeat (4) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      @(posedge sys_clk_i);
      t_regs();
      t_plain();
      t_evt();
      t_notify();
      close_out();
   end
endmodule
